// File: pkg/scs_defs.vh
// Purpose: constants for the system clock source select block
// Assumes: register port with byte-wide data, CLK_SYS at 200 MHz
// Notes:   offsets are word indexes on the plain register port
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

`define SCS_ADDR_W         4
`define SCS_OFF_OSC_CTRL   4'h0
`define SCS_OFF_OSC_TRIM   4'h1
`define SCS_OFF_PIN_CTRL   4'h2
`define SCS_OFF_STATUS     4'h3
`define SCS_OFF_WAKE       4'h4

`define SCS_FSEL_LSB       4
`define SCS_FSEL_MSB       5
`define SCS_HF_STABLE_BIT  2
`define SCS_LF_STABLE_BIT  1
`define SCS_FSEL_RESET     2'h1
`define SCS_FSEL_8M        2'h3
`define SCS_FSEL_4M        2'h2
`define SCS_FSEL_1M        2'h1
`define SCS_FSEL_31K       2'h0
`define SCS_TRIM_RESET     5'h00

`define SCS_CLK_MHZ        200
`define SCS_BIAS_DELAY_NS  10000
`define SCS_BIAS_CYC       ((`SCS_BIAS_DELAY_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_HF_START_CYC   64
`define SCS_LF_START_CYC   256
`define SCS_TRIM_STEP_CYC  4

`endif

// File: rtl/scs_div.v
// Purpose: divide an enable tick stream by a fixed power of two
// Assumes: tick_in is a one-cycle pulse on clk
// Notes:   tick_out fires on the last tick of each group
`timescale 1ns/1ps

module scs_div #(
	parameter W = 2
) (
	clk,
	rst,
	tick_in,
	tick_out
);
	input  wire clk;
	input  wire rst;
	input  wire tick_in;
	output wire tick_out;

	reg [W-1:0] cnt_reg;

	always @(posedge clk) begin
		if (rst) begin
			cnt_reg <= {W{1'b0}};
		end else if (tick_in) begin
			cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign tick_out = tick_in & (&cnt_reg);
endmodule // scs_div

// File: rtl/scs_clock_select.v
// Purpose: system clock source select, postscaler, trim, clock out and start-up hold
// Assumes: oscillators arrive as free-running pins; all of them are sampled on CLK_SYS
// Notes:   the system clock leaves as a tick enable so the selection stays glitch free
`timescale 1ns/1ps
`include "scs_defs.vh"

// Notes on behaviour
// - the external clock input is the system clock when the source fuse is one, else the internal oscillators.
// - the select field picks 8 MHz for 11, 4 MHz for 10, 1 MHz for 01 (reset) and 31 kHz for 00.
// - 8 MHz comes straight from the fast oscillator and 4 and 1 MHz come from a postscaler of it.
// - two read-only bits show fast oscillator stable in bit 2 and slow oscillator stable in bit 1.
// - with the active-low clock output fuse at zero the clock pin carries the internal clock divided by 4.
// - while the clock output drives the pin, a port read of that pin returns zero.
// - with the active-low clock output fuse at one the pin is released to general purpose use.
// - a 5-bit two's complement trim value is held and resets to zero.
// - trim 00000 is calibrated, 01111 is fastest, 10000 is slowest, ordered in between.
// - the trim acts on the fast oscillator only and not on the slow one.
// - after a trim change the applied trim walks to the new value in fewer than eight base cycles.
// - execution keeps going during the trim walk and no flag reports its end.
// - after power-on or wake-up operation is held until the selected oscillator has started.
// - waking onto an internal frequency adds a 10 us delay for the memory bias to settle.
// - logic is static, so a stopped external clock halts with state kept and resumes where it stopped.
module scs_clock_select (
	CLK_SYS,
	RST,
	CLOCK_SOURCE_FUSE,
	CLOCK_OUTPUT_ENABLE_N,
	CLOCK_INPUT_PIN,
	HF_OSC_PIN,
	LF_OSC_PIN,
	HF_OSC_RUNNING,
	LF_OSC_RUNNING,
	WAKE_EVENT,
	ADDR,
	WDATA,
	WR,
	RD,
	RDATA,
	SYS_CLK_TICK,
	RUN_ENABLE,
	HF_TRIM,
	CLOCK_OUTPUT_PIN_O,
	CLOCK_OUTPUT_PIN_OE,
	PIN_GPIO_OUT,
	PIN_GPIO_OE,
	PIN_READ_VALUE,
	PIN_INPUT
);
	input  wire                    CLK_SYS;
	input  wire                    RST;
	input  wire                    CLOCK_SOURCE_FUSE;
	input  wire                    CLOCK_OUTPUT_ENABLE_N;
	input  wire                    CLOCK_INPUT_PIN;
	input  wire                    HF_OSC_PIN;
	input  wire                    LF_OSC_PIN;
	input  wire                    HF_OSC_RUNNING;
	input  wire                    LF_OSC_RUNNING;
	input  wire                    WAKE_EVENT;
	input  wire [`SCS_ADDR_W-1:0]  ADDR;
	input  wire [7:0]              WDATA;
	input  wire                    WR;
	input  wire                    RD;
	output reg  [7:0]              RDATA;
	output wire                    SYS_CLK_TICK;
	output reg                     RUN_ENABLE;
	output reg  [4:0]              HF_TRIM;
	output reg                     CLOCK_OUTPUT_PIN_O;
	output reg                     CLOCK_OUTPUT_PIN_OE;
	output reg                     PIN_GPIO_OUT;
	output reg                     PIN_GPIO_OE;
	output reg                     PIN_READ_VALUE;
	input  wire                    PIN_INPUT;

	localparam ST_RUN   = 2'h0;
	localparam ST_START = 2'h1;
	localparam ST_BIAS  = 2'h2;

	// counts kept 32 bits wide here and cut to the counter width where compared
	localparam [31:0] HF_START_W  = `SCS_HF_START_CYC;
	localparam [31:0] LF_START_W  = `SCS_LF_START_CYC;
	localparam [31:0] BIAS_LAST_W = `SCS_BIAS_CYC - 1;
	localparam [31:0] TRIM_LAST_W = `SCS_TRIM_STEP_CYC - 1;

	// pin synchronisers: four flops each, only the last is read
	reg [1:0] ext_meta_reg, hf_meta_reg, lf_meta_reg, hfr_meta_reg, lfr_meta_reg, pin_meta_reg;
	reg [1:0] ext_sync_reg, hf_sync_reg, lf_sync_reg, hfr_sync_reg, lfr_sync_reg, pin_sync_reg;
	reg       ext_prev_reg, hf_prev_reg, lf_prev_reg;

	always @(posedge CLK_SYS) begin
		if (RST) begin
			ext_meta_reg <= 2'h0;
			ext_sync_reg <= 2'h0;
			hf_meta_reg  <= 2'h0;
			hf_sync_reg  <= 2'h0;
			lf_meta_reg  <= 2'h0;
			lf_sync_reg  <= 2'h0;
			hfr_meta_reg <= 2'h0;
			hfr_sync_reg <= 2'h0;
			lfr_meta_reg <= 2'h0;
			lfr_sync_reg <= 2'h0;
			pin_meta_reg <= 2'h0;
			pin_sync_reg <= 2'h0;
			ext_prev_reg <= 1'b0;
			hf_prev_reg  <= 1'b0;
			lf_prev_reg  <= 1'b0;
		end else begin
			ext_meta_reg <= {ext_meta_reg[0], CLOCK_INPUT_PIN};
			ext_sync_reg <= {ext_sync_reg[0], ext_meta_reg[1]};
			hf_meta_reg  <= {hf_meta_reg[0], HF_OSC_PIN};
			hf_sync_reg  <= {hf_sync_reg[0], hf_meta_reg[1]};
			lf_meta_reg  <= {lf_meta_reg[0], LF_OSC_PIN};
			lf_sync_reg  <= {lf_sync_reg[0], lf_meta_reg[1]};
			hfr_meta_reg <= {hfr_meta_reg[0], HF_OSC_RUNNING};
			hfr_sync_reg <= {hfr_sync_reg[0], hfr_meta_reg[1]};
			lfr_meta_reg <= {lfr_meta_reg[0], LF_OSC_RUNNING};
			lfr_sync_reg <= {lfr_sync_reg[0], lfr_meta_reg[1]};
			pin_meta_reg <= {pin_meta_reg[0], PIN_INPUT};
			pin_sync_reg <= {pin_sync_reg[0], pin_meta_reg[1]};
			ext_prev_reg <= ext_sync_reg[1];
			hf_prev_reg  <= hf_sync_reg[1];
			lf_prev_reg  <= lf_sync_reg[1];
		end
	end

	// rising-edge ticks, taken from the synchronised copies only
	wire ext_tick = ext_sync_reg[1] & ~ext_prev_reg;
	wire hf_tick  = hf_sync_reg[1] & ~hf_prev_reg;
	wire lf_tick  = lf_sync_reg[1] & ~lf_prev_reg;

	// registers
	reg [1:0] fsel_reg;
	reg [4:0] trim_reg;
	reg       gpio_out_reg;
	reg       gpio_oe_reg;
	reg       wake_sw_reg;

	always @(posedge CLK_SYS) begin
		if (RST) begin
			fsel_reg     <= `SCS_FSEL_RESET;
			trim_reg     <= `SCS_TRIM_RESET;
			gpio_out_reg <= 1'b0;
			gpio_oe_reg  <= 1'b0;
			wake_sw_reg  <= 1'b0;
		end else begin
			wake_sw_reg <= 1'b0;
			if (WR) begin
				case (ADDR)
					`SCS_OFF_OSC_CTRL: begin
						fsel_reg <= WDATA[`SCS_FSEL_MSB:`SCS_FSEL_LSB];
					end
					`SCS_OFF_OSC_TRIM: begin
						trim_reg <= WDATA[4:0];
					end
					`SCS_OFF_PIN_CTRL: begin
						gpio_out_reg <= WDATA[0];
						gpio_oe_reg  <= WDATA[1];
					end
					`SCS_OFF_WAKE: begin
						wake_sw_reg <= WDATA[0];
					end
					default: begin
						wake_sw_reg <= 1'b0;
					end
				endcase
			end
		end
	end

	// postscaler of the fast oscillator: 8 MHz tap direct, /2 gives 4 MHz, /8 gives 1 MHz
	wire hf_div2_tick;
	wire hf_div8_tick;

	scs_div #(.W(1)) u_div2 (
		.clk      (CLK_SYS),
		.rst      (RST),
		.tick_in  (hf_tick),
		.tick_out (hf_div2_tick)
	);

	scs_div #(.W(3)) u_div8 (
		.clk      (CLK_SYS),
		.rst      (RST),
		.tick_in  (hf_tick),
		.tick_out (hf_div8_tick)
	);

	// a new select is adopted only on a tick of the new source, so no partial period escapes
	reg [1:0] fsel_live_reg;
	reg       sel_tick;
	always @* begin
		case (fsel_reg)
			`SCS_FSEL_8M:  sel_tick = hf_tick;
			`SCS_FSEL_4M:  sel_tick = hf_div2_tick;
			`SCS_FSEL_1M:  sel_tick = hf_div8_tick;
			default:       sel_tick = lf_tick;
		endcase
	end

	reg live_tick;
	always @* begin
		case (fsel_live_reg)
			`SCS_FSEL_8M:  live_tick = hf_tick;
			`SCS_FSEL_4M:  live_tick = hf_div2_tick;
			`SCS_FSEL_1M:  live_tick = hf_div8_tick;
			default:       live_tick = lf_tick;
		endcase
	end

	always @(posedge CLK_SYS) begin
		if (RST) begin
			fsel_live_reg <= `SCS_FSEL_RESET;
		end else if (fsel_live_reg != fsel_reg && sel_tick) begin
			fsel_live_reg <= fsel_reg;
		end
	end

	// a stopped external clock gives no ticks, so everything gated by it just waits
	wire src_tick = CLOCK_SOURCE_FUSE ? ext_tick : live_tick;

	// start-up hold after reset or wake
	reg [1:0]  st_reg, st_next;
	reg [11:0] hold_cnt_reg, hold_cnt_next;
	wire       wake_req = WAKE_EVENT | wake_sw_reg;
	wire       osc_ok = (fsel_live_reg == `SCS_FSEL_31K) ? lfr_sync_reg[1] : hfr_sync_reg[1];

	always @* begin
		st_next       = st_reg;
		hold_cnt_next = hold_cnt_reg;
		case (st_reg)
			ST_RUN: begin
				if (wake_req) begin
					st_next       = ST_START;
					hold_cnt_next = 12'h000;
				end
			end
			ST_START: begin
				// external mode has no oscillator to wait for
				if (CLOCK_SOURCE_FUSE) begin
					st_next = ST_RUN;
				end else if (osc_ok) begin
					if (hold_cnt_reg == ((fsel_live_reg == `SCS_FSEL_31K) ? LF_START_W[11:0] :
						HF_START_W[11:0])) begin
						st_next       = ST_BIAS;
						hold_cnt_next = 12'h000;
					end else begin
						hold_cnt_next = hold_cnt_reg + 12'h001;
					end
				end
			end
			ST_BIAS: begin
				if (hold_cnt_reg == BIAS_LAST_W[11:0]) begin
					st_next = ST_RUN;
				end else begin
					hold_cnt_next = hold_cnt_reg + 12'h001;
				end
			end
			default: begin
				st_next = ST_START;
			end
		endcase
	end

	always @(posedge CLK_SYS) begin
		if (RST) begin
			st_reg       <= ST_START;
			hold_cnt_reg <= 12'h000;
			RUN_ENABLE   <= 1'b0;
		end else begin
			st_reg       <= st_next;
			hold_cnt_reg <= hold_cnt_next;
			RUN_ENABLE   <= (st_next == ST_RUN);
		end
	end

	assign SYS_CLK_TICK = src_tick & RUN_ENABLE;

	// applied trim walks one step per few cycles; full range fits inside eight fast periods
	reg [2:0] trim_step_cnt_reg;
	always @(posedge CLK_SYS) begin
		if (RST) begin
			HF_TRIM           <= `SCS_TRIM_RESET;
			trim_step_cnt_reg <= 3'h0;
		end else if (HF_TRIM != trim_reg) begin
			if (trim_step_cnt_reg == TRIM_LAST_W[2:0]) begin
				trim_step_cnt_reg <= 3'h0;
				// signed compare keeps 01111 fastest and 10000 slowest
				if ($signed(trim_reg) > $signed(HF_TRIM)) begin
					HF_TRIM <= HF_TRIM + 5'h01;
				end else begin
					HF_TRIM <= HF_TRIM - 5'h01;
				end
			end else begin
				trim_step_cnt_reg <= trim_step_cnt_reg + 3'h1;
			end
		end else begin
			trim_step_cnt_reg <= 3'h0;
		end
	end
	// HF_TRIM feeds only the fast oscillator; the slow one has no trim input

	// clock output: internal clock divided by 4
	reg [1:0] co_cnt_reg;
	always @(posedge CLK_SYS) begin
		if (RST) begin
			co_cnt_reg          <= 2'h0;
			CLOCK_OUTPUT_PIN_O  <= 1'b0;
			CLOCK_OUTPUT_PIN_OE <= 1'b0;
			PIN_GPIO_OUT        <= 1'b0;
			PIN_GPIO_OE         <= 1'b0;
			PIN_READ_VALUE      <= 1'b0;
		end else begin
			if (live_tick) begin
				co_cnt_reg <= co_cnt_reg + 2'h1;
			end
			CLOCK_OUTPUT_PIN_O  <= ~CLOCK_OUTPUT_ENABLE_N & co_cnt_reg[1];
			CLOCK_OUTPUT_PIN_OE <= ~CLOCK_OUTPUT_ENABLE_N;
			PIN_GPIO_OUT        <= CLOCK_OUTPUT_ENABLE_N & gpio_out_reg;
			PIN_GPIO_OE         <= CLOCK_OUTPUT_ENABLE_N & gpio_oe_reg;
			PIN_READ_VALUE      <= CLOCK_OUTPUT_ENABLE_N & pin_sync_reg[1];
		end
	end

	// register read, data one cycle after the strobe
	always @(posedge CLK_SYS) begin
		if (RST) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			case (ADDR)
				`SCS_OFF_OSC_CTRL: begin
					RDATA <= {2'h0, fsel_reg, 1'b0, hfr_sync_reg[1], lfr_sync_reg[1], 1'b0};
				end
				`SCS_OFF_OSC_TRIM: begin
					RDATA <= {3'h0, trim_reg};
				end
				`SCS_OFF_PIN_CTRL: begin
					RDATA <= {5'h00, PIN_READ_VALUE, gpio_oe_reg, gpio_out_reg};
				end
				`SCS_OFF_STATUS: begin
					RDATA <= {4'h0, st_reg, fsel_live_reg};
				end
				default: begin
					RDATA <= 8'h00;
				end
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end
endmodule // scs_clock_select

// File: sim/scs_ext_clk_src.sv
// Purpose: outside logic clock source feeding the clock input pin
// Assumes: half period counted in bench clock cycles
// Notes:   the pin rests low while stopped, as a gated source would
`timescale 1ns/1ps
module scs_ext_clk_src #(
	parameter int HALF = 5
) (
	input  wire logic clk,
	input  wire logic run,
	output logic      pin
);
	int cnt_reg = 0;
	initial pin = 1'b0;
	// 5 cycles each half at 200 MHz gives 20 MHz, the fastest allowed
	always @(posedge clk) begin
		if (!run) begin
			cnt_reg <= 0;
			pin     <= 1'b0;
		end else if (cnt_reg == HALF - 1) begin
			cnt_reg <= 0;
			pin     <= ~pin;
		end else
			cnt_reg <= cnt_reg + 1;
	end
endmodule // scs_ext_clk_src

// File: sim/scs_clock_select_assertions.sv
// Purpose: port checks for the clock select block
// Assumes: one clock domain, synchronous reset
// Notes:   start-up span restarts on reset or the wake pin, not on a register wake
`timescale 1ns/1ps
module scs_clock_select_assertions (
	input wire logic       CLK_SYS,
	input wire logic       RST,
	input wire logic       CLOCK_SOURCE_FUSE,
	input wire logic       CLOCK_OUTPUT_ENABLE_N,
	input wire logic       WAKE_EVENT,
	input wire logic       SYS_CLK_TICK,
	input wire logic       RUN_ENABLE,
	input wire logic [4:0] HF_TRIM,
	input wire logic       CLOCK_OUTPUT_PIN_OE,
	input wire logic       PIN_GPIO_OE,
	input wire logic       PIN_READ_VALUE
);
	logic [15:0] since_reg;
	always_ff @(posedge CLK_SYS)
		since_reg <= (RST || WAKE_EVENT) ? 16'h0000 : (&since_reg ? since_reg : since_reg + 16'h0001);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	a_tick_gated: assert property (!RUN_ENABLE |-> !SYS_CLK_TICK) else $error("tick while held");
	a_run_delay: assert property ($rose(RUN_ENABLE) && !CLOCK_SOURCE_FUSE |-> since_reg >= 16'h0810)
		else $error("run before start and bias delay");
	a_tick_single: assert property (SYS_CLK_TICK |=> !SYS_CLK_TICK) else $error("runt tick");
	a_pin_zero: assert property (CLOCK_OUTPUT_PIN_OE && $past(CLOCK_OUTPUT_PIN_OE) |-> !PIN_READ_VALUE)
		else $error("pin read not zero");
	a_clock_output_pin_on: assert property (!CLOCK_OUTPUT_ENABLE_N [*3] |-> CLOCK_OUTPUT_PIN_OE)
		else $error("clock out not driven");
	a_clock_output_pin_off: assert property (CLOCK_OUTPUT_ENABLE_N [*3] |-> !CLOCK_OUTPUT_PIN_OE)
		else $error("clock out not released");
	a_one_driver: assert property (!(CLOCK_OUTPUT_PIN_OE && PIN_GPIO_OE)) else $error("two pin drivers");
	a_trim_step: assert property ($changed(HF_TRIM) |->
		(HF_TRIM - $past(HF_TRIM) == 5'h01) || ($past(HF_TRIM) - HF_TRIM == 5'h01)) else $error("trim jump");
	a_trim_hold: assert property ($changed(HF_TRIM) |=> $stable(HF_TRIM) [*3]) else $error("trim step fast");
	a_trim_reset: assert property ($fell(RST) |-> HF_TRIM == 5'h00) else $error("trim not cleared");
	cover property ($rose(RUN_ENABLE));
	cover property (CLOCK_OUTPUT_PIN_OE && SYS_CLK_TICK);
	cover property ($changed(HF_TRIM));
endmodule // scs_clock_select_assertions
bind scs_clock_select scs_clock_select_assertions u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
	.CLOCK_SOURCE_FUSE(CLOCK_SOURCE_FUSE), .CLOCK_OUTPUT_ENABLE_N(CLOCK_OUTPUT_ENABLE_N),
	.WAKE_EVENT(WAKE_EVENT), .SYS_CLK_TICK(SYS_CLK_TICK), .RUN_ENABLE(RUN_ENABLE), .HF_TRIM(HF_TRIM),
	.CLOCK_OUTPUT_PIN_OE(CLOCK_OUTPUT_PIN_OE), .PIN_GPIO_OE(PIN_GPIO_OE), .PIN_READ_VALUE(PIN_READ_VALUE));

// File: sim/system_clock_source_select_bench.sv
// Purpose: self-checking bench for the clock select block
// Assumes: fast oscillator pin 8 MHz, slow pin sped up to 2.5 MHz
// Notes:   tick counts allow one tick of phase slack per window
`timescale 1ns/1ps
`include "scs_defs.vh"
module system_clock_source_select_bench;
	logic       clk = 0, rst = 1, fuse = 0, oen_n = 0, hf = 0, lf = 0, hf_run = 0, lf_run = 1;
	logic       wake = 0, wr = 0, rd = 0, pin_in = 1, ext_run = 0, co_q = 0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, d;
	wire  [7:0] rdata;
	wire  [4:0] trim;
	wire        tick, run, co_o, co_oe, g_out, g_oe, prv, ext_pin;
	int         err_count = 0, checks_done = 0, ticks = 0, edges = 0, n;
	logic [4:0] tv [3];
	always #2.5 clk = ~clk;
	always #62.5 hf = ~hf;
	// slow oscillator runs far above 31 kHz to keep the run short
	always #200 lf = ~lf;
	always @(posedge clk) begin
		if (tick === 1'b1) ticks++;
		co_q <= co_o;
		if (co_o === 1'b1 && co_q === 1'b0) edges++;
	end
	scs_ext_clk_src #(.HALF(5)) u_src (.clk(clk), .run(ext_run), .pin(ext_pin));
	scs_clock_select dut (.CLK_SYS(clk), .RST(rst), .CLOCK_SOURCE_FUSE(fuse), .CLOCK_OUTPUT_ENABLE_N(oen_n),
		.CLOCK_INPUT_PIN(ext_pin), .HF_OSC_PIN(hf), .LF_OSC_PIN(lf), .HF_OSC_RUNNING(hf_run),
		.LF_OSC_RUNNING(lf_run), .WAKE_EVENT(wake), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .SYS_CLK_TICK(tick), .RUN_ENABLE(run), .HF_TRIM(trim), .CLOCK_OUTPUT_PIN_O(co_o),
		.CLOCK_OUTPUT_PIN_OE(co_oe), .PIN_GPIO_OUT(g_out), .PIN_GPIO_OE(g_oe), .PIN_READ_VALUE(prv),
		.PIN_INPUT(pin_in));
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task cycles(input int k);
		repeat (k) @(posedge clk);
	endtask
	task wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a; wdata <= v; wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [3:0] a);
		@(posedge clk);
		addr <= a; rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task wait_run();
		n = 0;
		while (run !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
	endtask
	function int near(int s, int e);
		return (s >= e - 1 && s <= e + 1) ? e : s;
	endfunction
	// model: 2000-cycle window, 8 MHz = 80 ticks, postscaler /2 and /8, slow pin 25 ticks
	function int exp_ticks(int f);
		return f == 0 ? 25 : 80 / (f == 3 ? 1 : (f == 2 ? 2 : 8));
	endfunction
	task window(input int et, input int ec);
		ticks = 0;
		edges = 0;
		cycles(2000);
		check(near(ticks, et), et, "ticks");
		if (ec >= 0) check(near(edges, ec), ec, "clock out edges");
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#300000;
		err_count++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'hC6CD));
		cycles(12);
		rst <= 1'b0;
		cycles(4);
		rd_reg(`SCS_OFF_OSC_CTRL);
		check(d, 8'h12, "ctrl after reset");
		rd_reg(`SCS_OFF_OSC_TRIM);
		check(d, 8'h00, "trim after reset");
		hf_run <= 1'b1;
		wait_run();
		check(n >= `SCS_BIAS_CYC && n <= 2400, 1, "start hold");
		rd_reg(`SCS_OFF_OSC_CTRL);
		check(d, 8'h16, "both stable");
		rd_reg(`SCS_OFF_STATUS);
		check(d, 8'h01, "live select after start");
		rd_reg(4'hF);
		check(d, 8'h00, "unmapped read");
		for (int f = 3; f >= 0; f--) begin
			wr_reg(`SCS_OFF_OSC_CTRL, f << 4);
			cycles(250);
			rd_reg(`SCS_OFF_OSC_CTRL);
			check(d[5:4], f, "select");
			check(prv, 1'b0, "pin read in clock out");
			window(exp_ticks(f), exp_ticks(f) / 4);
		end
		tv = '{5'h0F, 5'h10, 5'($urandom)};
		foreach (tv[i]) begin
			wr_reg(`SCS_OFF_OSC_TRIM, {3'h0, tv[i]});
			cycles(160);
			check(trim, tv[i], "applied trim");
			rd_reg(`SCS_OFF_OSC_TRIM);
			check(d, {3'h0, tv[i]}, "trim read");
		end
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		cycles(3);
		check(run, 1'b0, "held after wake");
		wait_run();
		check(n >= `SCS_BIAS_CYC && n <= 2400, 1, "wake hold");
		wr_reg(`SCS_OFF_WAKE, 8'h01);
		cycles(3);
		check(run, 1'b0, "held after soft wake");
		wait_run();
		check(n >= `SCS_BIAS_CYC && n <= 2400, 1, "soft wake hold");
		oen_n <= 1'b1;
		wr_reg(`SCS_OFF_PIN_CTRL, 8'h03);
		cycles(6);
		check({co_oe, g_oe, g_out, prv}, 4'b0111, "gpio pin");
		rd_reg(`SCS_OFF_PIN_CTRL);
		check(d[2], 1'b1, "gpio read");
		fuse <= 1'b1;
		rst <= 1'b1;
		cycles(12);
		rst <= 1'b0;
		ext_run <= 1'b1;
		wait_run();
		check(run, 1'b1, "external run");
		window(200, -1);
		wr_reg(`SCS_OFF_OSC_TRIM, 8'h05);
		ext_run <= 1'b0;
		// let the trim walk to 05 finish before the stop is judged
		cycles(40);
		ticks = 0;
		cycles(500);
		check(ticks, 0, "stopped ticks");
		check(trim, 5'h05, "state kept");
		check(run, 1'b1, "run kept while stopped");
		ext_run <= 1'b1;
		window(200, -1);
		wrap_up();
	end
endmodule // system_clock_source_select_bench
